// >>> idb_pkg.sv
// Package of constants for the interrupt descriptor builder.
package idb_pkg;

	// ****************************************************************
	// Descriptor fields
	// ****************************************************************
	localparam int DIR_BIT      = 31;
	localparam int GRP_LO_MSB   = 30;
	localparam int GRP_LO_LSB   = 29;
	localparam int LANE_MSB     = 28;
	localparam int LANE_LSB     = 24;
	localparam int EVENT_MSB    = 23;
	localparam int EVENT_LSB    = 20;
	localparam int ERROR_MSB    = 19;
	localparam int ERROR_LSB    = 16;
	localparam int DROPPED_BIT  = 15;
	localparam int PARITY_BIT   = 13;
	localparam int GRP_HI_BIT   = 14;
	localparam int COUNT_MSB    = 12;
	localparam int COUNT_LSB    = 0;
	localparam int QLEN_W       = 15;
	localparam logic [14:0] QLEN_MIN = 15'h0001;
	localparam logic [31:0] DESC_RESET = 32'h0000_0000;

	// ****************************************************************
	// Event codes
	// ****************************************************************
	localparam logic [3:0] EV_NONE         = 4'h0;
	localparam logic [3:0] EV_SERVICE_DONE = 4'h1;
	localparam logic [3:0] EV_BUFFER_END   = 4'h2;
	localparam logic [3:0] EV_MESSAGE_END  = 4'h3;
	localparam logic [3:0] EV_PADFILL_END  = 4'h4;
	localparam logic [3:0] ERR_NONE        = 4'h0;

endpackage

// >>> idb_queue_if.sv
// Interface carrying descriptors from the builder into the internal queue.
`timescale 1ns/1ns
interface idb_queue_if;
	logic        push;
	logic [31:0] push_data;
	logic        full;
	logic        mark_dropped;
	logic        mark_parity;
	logic        pop;
	logic [31:0] head_data;
	logic        empty;
	modport builder (output push, output push_data, input full,
		output mark_dropped, output mark_parity,
		output pop, input head_data, input empty);
	modport queue (input push, input push_data, output full,
		input mark_dropped, input mark_parity,
		input pop, output head_data, output empty);
endinterface

// >>> idb_desc_fifo.sv
// Internal descriptor queue with marking of the newest entry.
`timescale 1ns/1ns
module idb_desc_fifo #(
	parameter int DEPTH = 8
) (
	input  wire logic  clock_in,
	input  wire logic  sys_rst_in,
	input  wire logic  enable_in,
	idb_queue_if.queue q
);
	localparam int AW = $clog2(DEPTH);

	logic [31:0]   mem_q [DEPTH];
	logic [31:0]   mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic [AW-1:0] last;
	logic [31:0]   head_mark;

	assign q.full      = (cnt_q == (AW+1)'(DEPTH));
	assign q.empty     = (cnt_q == '0);
	assign q.head_data = mem_q[rd_q] | head_mark;
	assign last        = wr_q - AW'(1);

	// The newest entry may leave in the very cycle it is marked, so the
	// mark is passed on with it rather than lost.
	always_comb begin
		head_mark = '0;
		if (rd_q == last && !q.empty) begin
			head_mark[idb_pkg::DROPPED_BIT] = q.mark_dropped;
			head_mark[idb_pkg::PARITY_BIT]  = q.mark_parity;
		end
	end

	always_comb begin
		mem_d = mem_q;
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		// Marks land on the newest entry, only one bit each.
		if (!q.empty && q.mark_dropped)
			mem_d[last][idb_pkg::DROPPED_BIT] = 1'b1;
		if (!q.empty && q.mark_parity)
			mem_d[last][idb_pkg::PARITY_BIT] = 1'b1;
		if (q.push && !q.full) begin
			mem_d[wr_q] = q.push_data;
			wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
		end
		if (q.pop && !q.empty)
			rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
		cnt_d = cnt_q + (AW+1)'(q.push && !q.full)
			- (AW+1)'(q.pop && !q.empty);
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= idb_pkg::DESC_RESET;
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (enable_in) begin
			mem_q <= mem_d;
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	property p_count_bound;
		@(posedge clock_in) disable iff (sys_rst_in)
		cnt_q <= (AW+1)'(DEPTH);
	endproperty
	a_count_bound: assert property (p_count_bound)
		else $error("Queue count exceeds depth.");
endmodule

// >>> idb_builder.sv
// Interrupt descriptor builder with shared memory queue writer.
`timescale 1ns/1ns
module idb_builder #(
	parameter int FIFO_DEPTH = 8,
	parameter int GROUPS     = 8
) (
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	input  wire logic        enable_in,
	input  wire logic [2:0]  group_in,
	input  wire logic [4:0]  lane_index_in,
	input  wire logic        dir_tx_in,
	input  wire logic        service_done_notice_in,
	input  wire logic        end_of_buffer_in,
	input  wire logic        buffer_end_notify_enable_in,
	input  wire logic [12:0] buffer_byte_count_in,
	input  wire logic        message_end_in,
	input  wire logic        padfill_end_in,
	input  wire logic        padfill_irq_enable_in,
	input  wire logic [7:0]  pad_count_in,
	input  wire logic        error_valid_in,
	input  wire logic [3:0]  error_code_in,
	input  wire logic        solo_event_valid_in,
	input  wire logic [3:0]  solo_event_code_in,
	input  wire logic        out_of_frame_in,
	input  wire logic        frame_alignment_shift_in,
	input  wire logic        bus_parity_fault_in,
	input  wire logic [31:0] queue_base_in,
	input  wire logic [14:0] queue_size_dwords_in,
	input  wire logic        mem_ready_in,
	output logic             mem_write_out,
	output logic [31:0]      mem_addr_out,
	output logic [31:0]      mem_data_out,
	output logic             accept_out
);
	idb_queue_if qi ();

	idb_desc_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.enable_in  (enable_in),
		.q          (qi)
	);

	// ****************************************************************
	// Descriptor assembly
	// ****************************************************************
	function automatic logic [31:0] pack(input logic dir,
		input logic [2:0] group_number_low, input logic [4:0] lane,
		input logic [3:0] ev, input logic [3:0] er,
		input logic [12:0] cnt);
		logic [31:0] d;
		d = idb_pkg::DESC_RESET;
		d[idb_pkg::DIR_BIT] = dir;
		d[idb_pkg::GRP_LO_MSB:idb_pkg::GRP_LO_LSB] = group_number_low[1:0];
		d[idb_pkg::GRP_HI_BIT] = group_number_low[2];
		d[idb_pkg::LANE_MSB:idb_pkg::LANE_LSB] = lane;
		d[idb_pkg::EVENT_MSB:idb_pkg::EVENT_LSB] = ev;
		d[idb_pkg::ERROR_MSB:idb_pkg::ERROR_LSB] = er;
		d[idb_pkg::COUNT_MSB:idb_pkg::COUNT_LSB] = cnt;
		return d;
	endfunction

	logic [GROUPS-1:0] frame_seen_q, frame_seen_d;
	logic              frame_cond;
	logic              frame_fire;
	logic              frame_take;
	logic              eob_ok, eom_ok, pad_ok;
	logic [3:0]        data_ev;
	logic              want;
	logic [31:0]       desc;

	assign frame_cond = out_of_frame_in | frame_alignment_shift_in;
	// One report per group until the condition clears and returns.
	assign frame_fire = frame_cond & ~frame_seen_q[group_in];
	assign eob_ok = end_of_buffer_in & buffer_end_notify_enable_in;
	assign eom_ok = message_end_in;
	assign pad_ok = padfill_end_in & padfill_irq_enable_in
		& (pad_count_in != 8'h00);

	always_comb begin
		frame_seen_d = frame_seen_q;
		// A report pushed aside by a busier item stays owed.
		frame_seen_d[group_in] = frame_cond
			& (frame_seen_q[group_in] | frame_take);
	end

	// Priority picks one item per cycle; only buffer or message end
	// may carry a simultaneous error. Solo items take precedence and
	// leave the rest to be raised again by their source.
	always_comb begin
		data_ev = eob_ok ? idb_pkg::EV_BUFFER_END :
			(eom_ok ? idb_pkg::EV_MESSAGE_END : idb_pkg::EV_NONE);
		want = 1'b1;
		frame_take = 1'b0;
		desc = idb_pkg::DESC_RESET;
		if (service_done_notice_in)
			desc = pack(dir_tx_in, group_in, lane_index_in,
				idb_pkg::EV_SERVICE_DONE, idb_pkg::ERR_NONE,
				13'h0000);
		else if (pad_ok)
			desc = pack(1'b1, group_in, lane_index_in,
				idb_pkg::EV_PADFILL_END, idb_pkg::ERR_NONE,
				13'h0000);
		else if (solo_event_valid_in)
			desc = pack(dir_tx_in, group_in, lane_index_in,
				solo_event_code_in, idb_pkg::ERR_NONE,
				13'h0000);
		else if (data_ev != idb_pkg::EV_NONE)
			desc = pack(dir_tx_in, group_in, lane_index_in, data_ev,
				error_valid_in ? error_code_in : idb_pkg::ERR_NONE,
				eob_ok ? buffer_byte_count_in : 13'h0000);
		else if (error_valid_in)
			desc = pack(dir_tx_in, group_in, lane_index_in,
				idb_pkg::EV_NONE, error_code_in, 13'h0000);
		else if (frame_fire) begin
			desc = pack(dir_tx_in, group_in, lane_index_in,
				idb_pkg::EV_NONE, error_code_in, 13'h0000);
			frame_take = 1'b1;
		end else
			want = 1'b0;
	end

	assign accept_out      = ~qi.full;
	assign qi.push         = want & enable_in;
	assign qi.push_data    = desc;
	// Lost and parity marks go onto the newest queued entry only.
	assign qi.mark_dropped = want & qi.full & enable_in;
	assign qi.mark_parity  = bus_parity_fault_in & enable_in;

	// ****************************************************************
	// Shared memory writer
	// ****************************************************************
	typedef enum logic [0:0] {ST_IDLE, ST_WRITE} idb_wr_e;
	idb_wr_e      st_q, st_d;
	logic [14:0]  slot_q, slot_d;
	logic         wr_q, wr_d;
	logic [31:0]  addr_q, addr_d, data_q, data_d;
	logic [14:0]  qlen;

	// A length below the minimum is treated as the minimum.
	assign qlen = (queue_size_dwords_in < idb_pkg::QLEN_MIN) ?
		idb_pkg::QLEN_MIN : queue_size_dwords_in;
	assign qi.pop = (st_q == ST_IDLE) & ~qi.empty & enable_in;

	always_comb begin
		st_d   = st_q;
		slot_d = slot_q;
		wr_d   = wr_q;
		addr_d = addr_q;
		data_d = data_q;
		case (st_q)
			ST_IDLE: begin
				if (!qi.empty) begin
					st_d   = ST_WRITE;
					wr_d   = 1'b1;
					data_d = qi.head_data;
					addr_d = queue_base_in + {15'h0000, slot_q, 2'b00};
				end
			end
			ST_WRITE: begin
				if (mem_ready_in) begin
					st_d   = ST_IDLE;
					wr_d   = 1'b0;
					slot_d = (slot_q >= qlen) ? 15'h0000 :
						slot_q + 15'h0001;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q         <= ST_IDLE;
			slot_q       <= 15'h0000;
			wr_q         <= 1'b0;
			addr_q       <= 32'h0000_0000;
			data_q       <= 32'h0000_0000;
			frame_seen_q <= '0;
		end else if (enable_in) begin
			st_q         <= st_d;
			slot_q       <= slot_d;
			wr_q         <= wr_d;
			addr_q       <= addr_d;
			data_q       <= data_d;
			frame_seen_q <= frame_seen_d;
		end
	end

	assign mem_write_out = wr_q;
	assign mem_addr_out  = addr_q;
	assign mem_data_out  = data_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_frame_once;
		@(posedge clock_in) disable iff (sys_rst_in)
		(enable_in && frame_take) |=> !frame_fire || !frame_cond
			|| $changed(group_in);
	endproperty
	a_frame_once: assert property (p_frame_once)
		else $error("Framing reported twice in a group.");

	property p_solo;
		@(posedge clock_in) disable iff (sys_rst_in)
		(qi.push && (service_done_notice_in || pad_ok))
		|-> desc[idb_pkg::ERROR_MSB:idb_pkg::ERROR_LSB] == 4'h0
		&& desc[idb_pkg::EVENT_MSB:idb_pkg::EVENT_LSB] ==
		(service_done_notice_in ? idb_pkg::EV_SERVICE_DONE :
		idb_pkg::EV_PADFILL_END);
	endproperty
	a_solo: assert property (p_solo)
		else $error("Solo item shares its descriptor.");

	property p_pad_gate;
		@(posedge clock_in) disable iff (sys_rst_in)
		(qi.push && desc[idb_pkg::EVENT_MSB:idb_pkg::EVENT_LSB]
		== idb_pkg::EV_PADFILL_END) |-> padfill_irq_enable_in
		&& pad_count_in != 8'h00 && desc[idb_pkg::DIR_BIT];
	endproperty
	a_pad_gate: assert property (p_pad_gate)
		else $error("Padfill end without enable.");

	property p_count;
		@(posedge clock_in) disable iff (sys_rst_in)
		(qi.push && eob_ok && !service_done_notice_in && !pad_ok
		&& !solo_event_valid_in) |-> desc[12:0] == buffer_byte_count_in;
	endproperty
	a_count: assert property (p_count)
		else $error("Buffer end lacks byte count.");

	property p_lane;
		@(posedge clock_in) disable iff (sys_rst_in)
		qi.push |-> desc[idb_pkg::LANE_MSB:idb_pkg::LANE_LSB]
		== lane_index_in && desc[idb_pkg::GRP_HI_BIT] == group_in[2];
	endproperty
	a_lane: assert property (p_lane)
		else $error("Source identity wrong.");

	property p_write_hold;
		@(posedge clock_in) disable iff (sys_rst_in)
		(mem_write_out && !mem_ready_in && enable_in) |=>
		mem_write_out && $stable(mem_data_out);
	endproperty
	a_write_hold: assert property (p_write_hold)
		else $error("Write dropped before ready.");

	property p_wrap;
		@(posedge clock_in) disable iff (sys_rst_in)
		(enable_in && mem_write_out && mem_ready_in && slot_q >= qlen)
		|=> slot_q == 15'h0000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("Queue slot did not wrap.");

	property p_lost;
		@(posedge clock_in) disable iff (sys_rst_in)
		qi.mark_dropped |-> qi.full && !(qi.push && !qi.full);
	endproperty
	a_lost: assert property (p_lost)
		else $error("Lost mark formed a descriptor.");

	c_write: cover property (@(posedge clock_in)
		mem_write_out && mem_ready_in);
	c_lost: cover property (@(posedge clock_in) qi.mark_dropped);
	c_frame: cover property (@(posedge clock_in) frame_fire);
endmodule

// >>> idb_host_mem.sv
// Host memory model that takes descriptor writes into the shared queue.
`timescale 1ns/1ns
module idb_host_mem (
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	input  wire logic [7:0]  delay_in,
	input  wire logic        mem_write_in,
	input  wire logic [31:0] mem_addr_in,
	input  wire logic [31:0] mem_data_in,
	output logic             ready_out
);
	logic [31:0] got_addr [0:63];
	logic [31:0] got_data [0:63];
	int          n_got;
	logic [7:0]  wait_q;

	// ****************************************************************
	// Write acceptance
	// ****************************************************************
	// A slow answer only stalls the writer; the queue is never refused.
	// Ready is raised after an edge and dropped at the edge it is taken.
	// Only queue words are stored; no buffer status entry is rewritten.
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ready_out <= 1'b0;
			wait_q <= 8'h00;
			n_got <= 0;
		end else if (ready_out && mem_write_in) begin
			got_addr[n_got] <= mem_addr_in;
			got_data[n_got] <= mem_data_in;
			n_got <= n_got + 1;
			ready_out <= 1'b0;
			wait_q <= 8'h00;
		end else if (mem_write_in && wait_q >= delay_in) begin
			ready_out <= 1'b1;
		end else if (mem_write_in) begin
			wait_q <= wait_q + 8'h01;
		end
	end
endmodule

// >>> interrupt_descriptor_builder_bench.sv
// Self-checking bench for the interrupt descriptor builder.
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module interrupt_descriptor_builder_bench;
	localparam logic [31:0] BASE = 32'h0010_0000;
	localparam logic [14:0] QL = 15'h0003;
	logic clock_in = 1'b0, sys_rst_in = 1'b1, enable_in = 1'b1;
	logic [2:0] group_in = 3'h0;
	logic [4:0] lane_index_in = 5'h00;
	logic dir_tx_in = 1'b0, service_done_notice_in = 1'b0;
	logic end_of_buffer_in = 1'b0, buffer_end_notify_enable_in = 1'b1;
	logic [12:0] buffer_byte_count_in = 13'h0000;
	logic message_end_in = 1'b0, padfill_end_in = 1'b0;
	logic padfill_irq_enable_in = 1'b1;
	logic [7:0] pad_count_in = 8'h03, delay = 8'h00;
	logic error_valid_in = 1'b0, solo_event_valid_in = 1'b0;
	logic [3:0] error_code_in = 4'h0, solo_event_code_in = 4'h5;
	logic out_of_frame_in = 1'b0, frame_alignment_shift_in = 1'b0;
	logic bus_parity_fault_in = 1'b0, mem_ready_in, mem_write_out;
	logic [31:0] mem_addr_out, mem_data_out;
	logic accept_out;
	int failures = 0, n_checks = 0, n_seen = 0, slot = 0, j;
	logic [31:0] exp_w;

	always #4 clock_in = ~clock_in;

	idb_builder i_idb_builder (.clock_in, .sys_rst_in, .enable_in,
		.group_in, .lane_index_in, .dir_tx_in, .service_done_notice_in,
		.end_of_buffer_in, .buffer_end_notify_enable_in,
		.buffer_byte_count_in, .message_end_in, .padfill_end_in,
		.padfill_irq_enable_in, .pad_count_in, .error_valid_in,
		.error_code_in, .solo_event_valid_in, .solo_event_code_in,
		.out_of_frame_in, .frame_alignment_shift_in, .bus_parity_fault_in,
		.queue_base_in(BASE), .queue_size_dwords_in(QL), .mem_ready_in,
		.mem_write_out, .mem_addr_out, .mem_data_out, .accept_out);
	idb_host_mem i_idb_host_mem (.clock_in, .sys_rst_in, .delay_in(delay),
		.mem_write_in(mem_write_out), .mem_addr_in(mem_addr_out),
		.mem_data_in(mem_data_out), .ready_out(mem_ready_in));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] mk(input logic d, input logic [2:0] g,
		input logic [4:0] l, input logic [3:0] ev, input logic [3:0] er,
		input logic [12:0] c);
		return {d, g[1:0], l, ev, er, 1'b0, g[2], 1'b0, c};
	endfunction

	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Kind: 0 service, 1 buffer end, 2 message end, 3 padfill, 4 solo.
	task automatic pulse(input int k, input logic d, input logic [2:0] g,
		input logic [4:0] l, input logic [3:0] er);
		@(posedge clock_in);
		dir_tx_in <= d;
		group_in <= g;
		lane_index_in <= l;
		error_code_in <= er;
		error_valid_in <= (er != 4'h0);
		case (k)
			0: service_done_notice_in <= 1'b1;
			1: end_of_buffer_in <= 1'b1;
			2: message_end_in <= 1'b1;
			3: padfill_end_in <= 1'b1;
			4: solo_event_valid_in <= 1'b1;
			default: ;
		endcase
		@(posedge clock_in);
		{service_done_notice_in, end_of_buffer_in, message_end_in} <= 3'h0;
		{padfill_end_in, solo_event_valid_in, error_valid_in} <= 3'h0;
	endtask

	// Waits for the next queue write and checks its slot and word.
	task automatic expect_desc(input logic [31:0] d);
		int i;
		for (i = 0; i < 2000 && i_idb_host_mem.n_got <= n_seen; i++)
			@(posedge clock_in);
		if (i_idb_host_mem.n_got <= n_seen) begin
			failures++;
			$display("[FAIL] t=%0t no descriptor written", $time);
			stop_test();
		end else begin
			`CHK(i_idb_host_mem.got_addr[n_seen], BASE + 32'(slot) * 4)
			`CHK(i_idb_host_mem.got_data[n_seen], d)
			n_seen++;
			slot = (slot == int'(QL)) ? 0 : slot + 1;
		end
	endtask

	// ****************************************************************
	// Sequence
	// ****************************************************************
	// Count field stays zero for events other than buffer end.
	initial begin
		repeat (16) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		pulse(0, 1'b0, 3'h5, 5'h1F, 4'h0);
		expect_desc(mk(1'b0, 3'h5, 5'h1F, 4'h1, 4'h0, 13'h0));
		buffer_byte_count_in <= 13'h1ABC;
		pulse(1, 1'b1, 3'h2, 5'h03, 4'h3);
		expect_desc(mk(1'b1, 3'h2, 5'h03, 4'h2, 4'h3, 13'h1ABC));
		pulse(2, 1'b1, 3'h4, 5'h00, 4'h0);
		expect_desc(mk(1'b1, 3'h4, 5'h00, 4'h3, 4'h0, 13'h0));
		pulse(3, 1'b0, 3'h1, 5'h09, 4'h0);
		expect_desc(mk(1'b1, 3'h1, 5'h09, 4'h4, 4'h0, 13'h0));
		pad_count_in <= 8'h00;
		pulse(3, 1'b1, 3'h1, 5'h09, 4'h0);
		buffer_end_notify_enable_in <= 1'b0;
		pulse(1, 1'b0, 3'h1, 5'h09, 4'h0);
		enable_in <= 1'b0;
		pulse(0, 1'b1, 3'h1, 5'h09, 4'h0);
		enable_in <= 1'b1;
		pulse(5, 1'b0, 3'h1, 5'h07, 4'h9);
		expect_desc(mk(1'b0, 3'h1, 5'h07, 4'h0, 4'h9, 13'h0));
		pulse(4, 1'b0, 3'h3, 5'h11, 4'h2);
		expect_desc(mk(1'b0, 3'h3, 5'h11, 4'h5, 4'h0, 13'h0));
		pulse(5, 1'b1, 3'h6, 5'h0C, 4'hA);
		expect_desc(mk(1'b1, 3'h6, 5'h0C, 4'h0, 4'hA, 13'h0));
		@(posedge clock_in);
		error_code_in <= 4'hA;
		out_of_frame_in <= 1'b1;
		expect_desc(mk(1'b1, 3'h6, 5'h0C, 4'h0, 4'hA, 13'h0));
		repeat (20) @(posedge clock_in);
		`CHK(i_idb_host_mem.n_got, n_seen)
		out_of_frame_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		error_code_in <= 4'hB;
		frame_alignment_shift_in <= 1'b1;
		expect_desc(mk(1'b1, 3'h6, 5'h0C, 4'h0, 4'hB, 13'h0));
		@(posedge clock_in);
		frame_alignment_shift_in <= 1'b0;
		delay <= 8'h3C;
		for (j = 0; j < 12; j++) pulse(2, 1'b0, 3'h7, 5'(j), 4'h0);
		@(posedge clock_in);
		`CHK(accept_out, 1'b0)
		bus_parity_fault_in <= 1'b1;
		@(posedge clock_in);
		bus_parity_fault_in <= 1'b0;
		delay <= 8'h00;
		for (j = 0; j < 8; j++)
			expect_desc(mk(1'b0, 3'h7, 5'(j), 4'h3, 4'h0, 13'h0));
		exp_w = mk(1'b0, 3'h7, 5'h08, 4'h3, 4'h0, 13'h0);
		expect_desc(exp_w | 32'h0000_A000);
		repeat (30) @(posedge clock_in);
		`CHK(i_idb_host_mem.n_got, n_seen)
		stop_test();
	end
endmodule
